// ---- common/timer0_params.svh ----
// Named constants for the timer 0 block with its fast edge counter.
// Assumes inclusion by bare name from the package and the design file.
`ifndef TIMER0_PARAMS_SVH
`define TIMER0_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index.
`define T0_IDX_CONTROL 16'hfe10
`define T0_IDX_PRESCALE 16'hfe11
`define T0_IDX_LOW_COUNT 16'hfe12
`define T0_IDX_HIGH_COUNT 16'hfe13
`define T0_IDX_LOW_MATCH 16'hfe14
`define T0_IDX_HIGH_MATCH 16'hfe15
`define T0_IDX_LOW_CAPTURE 16'hfe16
`define T0_IDX_HIGH_CAPTURE 16'hfe17
`define T0_IDX_PORT1_TEST 16'hfe47
`define T0_IDX_EDGE_CTRL 16'hfe7d

// Bus geometry.
`define T0_ADDR_W 18
`define T0_IDX_LSB 2

// Reset values.
`define T0_RST_8 8'h00
`define T0_RST_EDGE 3'h0

// Field positions in timer0_control.
`define T0_CTL_HIGH_RUN 7
`define T0_CTL_LOW_RUN 6
`define T0_CTL_LENGTH 5
`define T0_CTL_LOW_CLK 4
`define T0_CTL_HIGH_FLAG 3
`define T0_CTL_HIGH_IE 2
`define T0_CTL_LOW_FLAG 1
`define T0_CTL_LOW_IE 0

// Field positions in edge_counter_control.
`define T0_EDGE_EN 7
`define T0_EDGE_CMP_HI 6
`define T0_EDGE_CMP_LO 4

// Field position of the realtime output enable in port1_test_control.
`define T0_P1_RT_EN 2
// Read image of port1_test_control around the enable bit (bit 5 reads one).
`define T0_P1_FIXED 8'h20

// Counter extremes.
`define T0_FULL_8 8'hff
`define T0_FULL_EDGE 3'h7

// Bus response codes.
`define T0_RESP_OKAY 2'h0
`define T0_RESP_SLVERR 2'h2

`endif

// ---- common/timer0_pkg.sv ----
// Types shared by the timer 0 block.
// Assumes the constants header sits beside it on the include path.
`default_nettype none
`include "timer0_params.svh"
package timer0_pkg;
    typedef logic [7:0] reg8_t;
    typedef logic [2:0] edge_t;
    typedef logic [19:0] count20_t;
    typedef logic [`T0_ADDR_W-1:0] addr_t;
endpackage : timer0_pkg
`default_nettype wire

// ---- design/timer0_with_fast_edge_counter.sv ----
// Timer 0: two 8-bit halves with prescaler, captures and a 3-bit fast edge counter.
// Assumes one 250 MHz clock, event inputs as one-cycle pulses synchronous to it,
// and an AXI4-Lite master on the register side.
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
`include "timer0_params.svh"

module timer0_with_fast_edge_counter (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // AXI4-Lite write address and data.
    input wire logic i_awvalid,
    output logic o_awready,
    input wire timer0_pkg::addr_t i_awaddr,
    input wire logic [2:0] i_awprot,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response.
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read.
    input wire logic i_arvalid,
    output logic o_arready,
    input wire timer0_pkg::addr_t i_araddr,
    input wire logic [2:0] i_arprot,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // External detection events.
    input wire logic i_ext_count,
    input wire logic i_edge_pulse,
    input wire logic i_low_capture,
    input wire logic i_high_capture,
    // Realtime output pin.
    input wire logic i_port_latch,
    output logic o_realtime,
    // Interrupt requests.
    output logic o_irq_high,
    output logic o_irq_low
);

    // Software-visible state.
    timer0_pkg::reg8_t control;
    timer0_pkg::reg8_t prescale_match;
    timer0_pkg::reg8_t low_match;
    timer0_pkg::reg8_t high_match;
    timer0_pkg::reg8_t low_capture;
    timer0_pkg::reg8_t high_capture;
    logic realtime_output_enable;
    logic edge_counter_enable;
    timer0_pkg::edge_t edge_compare_field;
    logic edge_capture_carry;
    timer0_pkg::edge_t edge_capture_field;

    // Counting state.
    timer0_pkg::reg8_t pre_cnt;
    timer0_pkg::reg8_t low_cnt;
    timer0_pkg::reg8_t high_cnt;
    timer0_pkg::reg8_t low_buf;
    timer0_pkg::reg8_t high_buf;
    timer0_pkg::edge_t edge_cnt;
    logic edge_armed;
    logic rt_held;

    // Bus state.
    logic aw_held;
    logic w_held;
    timer0_pkg::addr_t aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;

    // Control fields, named for readability.
    logic high_run;
    logic low_run;
    logic length_sel;
    logic low_clock_select;
    assign high_run = control[`T0_CTL_HIGH_RUN];
    assign low_run = control[`T0_CTL_LOW_RUN];
    assign length_sel = control[`T0_CTL_LENGTH];
    assign low_clock_select = control[`T0_CTL_LOW_CLK];

    // Write decode: a write lands once both halves of the request are held.
    logic wr_fire;
    logic [15:0] wr_idx;
    logic wr_ctl;
    logic wr_pre;
    logic wr_lm;
    logic wr_hm;
    logic wr_p1;
    logic wr_edge;
    logic wr_known;
    assign wr_fire = aw_held && w_held && !o_bvalid;
    assign wr_idx = aw_addr[`T0_ADDR_W-1:`T0_IDX_LSB];
    assign wr_ctl = wr_fire && w_lane0 && (wr_idx == `T0_IDX_CONTROL);
    assign wr_pre = wr_fire && w_lane0 && (wr_idx == `T0_IDX_PRESCALE);
    assign wr_lm = wr_fire && w_lane0 && (wr_idx == `T0_IDX_LOW_MATCH);
    assign wr_hm = wr_fire && w_lane0 && (wr_idx == `T0_IDX_HIGH_MATCH);
    assign wr_p1 = wr_fire && w_lane0 && (wr_idx == `T0_IDX_PORT1_TEST);
    assign wr_edge = wr_fire && w_lane0 && (wr_idx == `T0_IDX_EDGE_CTRL);
    // Read-only registers are mapped, so writes to them answer OKAY and do nothing.
    assign wr_known = (wr_idx == `T0_IDX_CONTROL) || (wr_idx == `T0_IDX_PRESCALE) ||
                      (wr_idx == `T0_IDX_LOW_COUNT) || (wr_idx == `T0_IDX_HIGH_COUNT) ||
                      (wr_idx == `T0_IDX_LOW_MATCH) || (wr_idx == `T0_IDX_HIGH_MATCH) ||
                      (wr_idx == `T0_IDX_LOW_CAPTURE) || (wr_idx == `T0_IDX_HIGH_CAPTURE) ||
                      (wr_idx == `T0_IDX_PORT1_TEST) || (wr_idx == `T0_IDX_EDGE_CTRL);

    // Ready while the slot is empty; the slave accepts address and data in either order.
    assign o_awready = !aw_held;
    assign o_wready = !w_held;
    assign o_arready = !o_rvalid;

    // Write address holding slot.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (i_awvalid && o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Write data holding slot; registers are 8 bits wide so only lane 0 matters.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            w_held <= 1'b0;
            w_byte <= `T0_RST_8;
            w_lane0 <= 1'b0;
        end else if (i_wvalid && o_wready) begin
            w_held <= 1'b1;
            w_byte <= i_wdata[7:0];
            w_lane0 <= i_wstrb[0];
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Write response, one cycle after both slots are full.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_bvalid <= 1'b0;
            o_bresp <= `T0_RESP_OKAY;
        end else if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_known ? `T0_RESP_OKAY : `T0_RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Prescaler: a write to its match register restarts it, so the next tick is a full period away.
    logic pre_tick;
    assign pre_tick = (pre_cnt == prescale_match) && !wr_pre;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_cnt <= `T0_RST_8;
        end else if (wr_pre || pre_tick) begin
            pre_cnt <= `T0_RST_8;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
    end

    // Edge counter steps while the low half runs with the edge counter enabled.
    logic edge_step;
    logic edge_carry;
    assign edge_step = edge_counter_enable && low_run && i_edge_pulse;
    assign edge_carry = edge_step && (edge_cnt == `T0_FULL_EDGE);
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            edge_cnt <= `T0_RST_EDGE;
        end else if (!edge_counter_enable || !low_run) begin
            edge_cnt <= `T0_RST_EDGE;
        end else if (edge_step) begin
            edge_cnt <= edge_cnt + 3'h1;
        end
    end

    // Count clocks and normal match events; edge mode makes the low half free-running, and the high half only when joined in 16-bit mode.
    logic low_clk;
    logic high_clk;
    logic full_eq;
    logic low_evt;
    logic high_evt;
    assign low_clk = edge_counter_enable ? edge_carry : (low_clock_select ? i_ext_count : pre_tick);
    assign high_clk = length_sel ? (low_clk && (low_cnt == `T0_FULL_8)) : pre_tick;
    assign full_eq = ({high_cnt, low_cnt} == {high_buf, low_buf});
    assign low_evt = !edge_counter_enable && low_run && low_clk &&
                     (length_sel ? (high_run && full_eq) : (low_cnt == low_buf));
    assign high_evt = length_sel ? low_evt : (high_run && pre_tick && (high_cnt == high_buf));

    // Low counter: stopped at zero, wraps to zero on its match.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_cnt <= `T0_RST_8;
        end else if (!low_run || low_evt) begin
            low_cnt <= `T0_RST_8;
        end else if (low_clk) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end

    // High counter: counts ticks alone or low overflows when joined.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            high_cnt <= `T0_RST_8;
        end else if (!high_run || high_evt) begin
            high_cnt <= `T0_RST_8;
        end else if (high_clk) begin
            high_cnt <= high_cnt + 8'h01;
        end
    end

    // Match buffers: follow the register while stopped, reload only on a match while running.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_buf <= `T0_RST_8;
            high_buf <= `T0_RST_8;
        end else begin
            if (!low_run || low_evt) begin
                low_buf <= low_match;
            end
            if (!high_run || high_evt) begin
                high_buf <= high_match;
            end
        end
    end

    // Combined count and target: the target is the match value plus one, times 8, plus the compare field.
    timer0_pkg::count20_t count_all;
    timer0_pkg::count20_t target_all;
    logic edge_hit;
    assign count_all = length_sel ? {1'b0, high_cnt, low_cnt, edge_cnt} : {9'h000, low_cnt, edge_cnt};
    assign target_all = length_sel ? {({1'b0, high_match, low_match} + 17'h0_0001), edge_compare_field} :
                        {8'h00, ({1'b0, low_match} + 9'h001), edge_compare_field};
    assign edge_hit = edge_counter_enable && edge_armed && (count_all == target_all);

    // Flags are set by hardware and written by software; a set in the same cycle wins.
    logic set_low;
    logic set_high;
    assign set_low = low_evt || edge_hit;
    assign set_high = high_evt || (edge_hit && length_sel);

    // Timer 0 control register with its two sticky flags.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            control <= `T0_RST_8;
        end else begin
            if (wr_ctl) begin
                control <= w_byte;
            end
            if (set_high) begin
                control[`T0_CTL_HIGH_FLAG] <= 1'b1;
            end
            if (set_low) begin
                control[`T0_CTL_LOW_FLAG] <= 1'b1;
            end
        end
    end

    // Plain software registers.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prescale_match <= `T0_RST_8;
            low_match <= `T0_RST_8;
            high_match <= `T0_RST_8;
            realtime_output_enable <= 1'b0;
        end else begin
            if (wr_pre) begin
                prescale_match <= w_byte;
            end
            if (wr_lm) begin
                low_match <= w_byte;
            end
            if (wr_hm) begin
                high_match <= w_byte;
            end
            if (wr_p1) begin
                realtime_output_enable <= w_byte[`T0_P1_RT_EN];
            end
        end
    end

    // Edge control: each write that sets the enable bit re-arms matching, and a hit disarms it until the next such write.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            edge_counter_enable <= 1'b0;
            edge_compare_field <= `T0_RST_EDGE;
            edge_armed <= 1'b0;
            rt_held <= 1'b0;
        end else if (wr_edge) begin
            edge_counter_enable <= w_byte[`T0_EDGE_EN];
            edge_compare_field <= w_byte[`T0_EDGE_CMP_HI:`T0_EDGE_CMP_LO];
            edge_armed <= w_byte[`T0_EDGE_EN];
            rt_held <= o_realtime;
        end else if (edge_hit) begin
            edge_armed <= 1'b0;
        end
    end

    // Captures; the low capture follows the high-half source in 16-bit mode.
    logic low_cap_evt;
    assign low_cap_evt = length_sel ? i_high_capture : i_low_capture;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_capture <= `T0_RST_8;
            high_capture <= `T0_RST_8;
            edge_capture_field <= `T0_RST_EDGE;
            edge_capture_carry <= 1'b0;
        end else begin
            if (low_cap_evt) begin
                low_capture <= low_cnt;
                edge_capture_field <= edge_cnt;
                edge_capture_carry <= edge_carry;
            end
            if (i_high_capture) begin
                high_capture <= high_cnt;
            end
        end
    end

    // Realtime output is combinational so the new level appears in the hit cycle itself.
    always_comb begin
        if (realtime_output_enable && edge_counter_enable && edge_armed && !edge_hit) begin
            o_realtime = rt_held;
        end else begin
            o_realtime = i_port_latch;
        end
    end

    // Interrupt requests.
    assign o_irq_high = control[`T0_CTL_HIGH_IE] && control[`T0_CTL_HIGH_FLAG];
    assign o_irq_low = control[`T0_CTL_LOW_IE] && control[`T0_CTL_LOW_FLAG];

    // Read path, answered one cycle after the address is taken.
    logic [7:0] rd_byte;
    logic rd_known;
    logic [15:0] rd_idx;
    assign rd_idx = i_araddr[`T0_ADDR_W-1:`T0_IDX_LSB];
    always_comb begin
        rd_byte = `T0_RST_8;
        rd_known = 1'b1;
        case (rd_idx)
            `T0_IDX_CONTROL: rd_byte = control;
            `T0_IDX_PRESCALE: rd_byte = prescale_match;
            `T0_IDX_LOW_COUNT: rd_byte = low_cnt;
            `T0_IDX_HIGH_COUNT: rd_byte = high_cnt;
            `T0_IDX_LOW_MATCH: rd_byte = low_match;
            `T0_IDX_HIGH_MATCH: rd_byte = high_match;
            `T0_IDX_LOW_CAPTURE: rd_byte = low_capture;
            `T0_IDX_HIGH_CAPTURE: rd_byte = high_capture;
            `T0_IDX_PORT1_TEST: begin
                rd_byte = `T0_P1_FIXED;
                rd_byte[`T0_P1_RT_EN] = realtime_output_enable;
            end
            `T0_IDX_EDGE_CTRL: rd_byte = {edge_counter_enable, edge_compare_field,
                                          edge_capture_carry, edge_capture_field};
            default: rd_known = 1'b0;
        endcase
    end

    // Read response register.
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= `T0_RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= {24'h00_0000, rd_byte};
            o_rresp <= rd_known ? `T0_RESP_OKAY : `T0_RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // Checks on the counting logic.
    default clocking chk_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    high_stop_a: assert property (!high_run |=> high_cnt == 8'h00 && high_buf == $past(high_match))
        else $error("high half not parked while stopped");
    low_stop_a: assert property (!low_run |=> low_cnt == 8'h00 && low_buf == $past(low_match))
        else $error("low half not parked while stopped");
    buf_hold_a: assert property (high_run && !high_evt |=> $stable(high_buf))
        else $error("high buffer changed without a match");
    long_pair_a: assert property (length_sel && low_evt |=> control[`T0_CTL_HIGH_FLAG] && control[`T0_CTL_LOW_FLAG])
        else $error("16-bit match did not set both flags");
    // A setting of zero ticks on every cycle, so only then may a tick follow the restart at once.
    pre_restart_a: assert property (wr_pre |=> pre_cnt == 8'h00 && (!pre_tick || prescale_match == 8'h00))
        else $error("prescaler not restarted by write");
    pre_period_a: assert property (pre_tick && prescale_match == 8'h02 ##1 !wr_pre [*3] |-> pre_tick)
        else $error("prescaler period wrong");
    low_flag_a: assert property (set_low |=> control[`T0_CTL_LOW_FLAG])
        else $error("low flag missed a match");
    high_irq_a: assert property (high_evt && control[`T0_CTL_HIGH_IE] && !wr_ctl |=> o_irq_high)
        else $error("high interrupt not raised");
    edge_disarm_a: assert property (edge_hit && !wr_edge |=> !edge_hit [*2])
        else $error("edge match repeated without a write");
    capture_a: assert property (low_cap_evt |=> low_capture == $past(low_cnt) &&
                                edge_capture_field == $past(edge_cnt))
        else $error("low capture lost data");

    cover_long_match: cover property (length_sel && low_evt);
    cover_edge_hit: cover property (edge_hit && realtime_output_enable);
    cover_capture_carry: cover property (low_cap_evt && edge_carry);
    cover_prescale: cover property (pre_tick && prescale_match == 8'h03);

endmodule : timer0_with_fast_edge_counter
`default_nettype wire

// ---- verification/timer0_event_model.sv ----
// Model of the external detection pins that feed timer 0.
// Assumes the bench calls its tasks from one process at a time.
`default_nettype none
module timer0_event_model (
    // Clock.
    input wire logic i_clk,
    // Detection pulses.
    output logic o_ext_count,
    output logic o_edge_pulse,
    output logic o_low_capture,
    output logic o_high_capture
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] line = 4'h0;
    // Each line idles low, since a detector reports one-cycle events only.
    assign {o_high_capture, o_low_capture, o_edge_pulse, o_ext_count} = line;
    // Pulse one line n times with an idle cycle between pulses.
    task automatic pulse(input int sel, input int n);
        repeat (n) begin
            @(posedge i_clk);
            line[sel] <= 1'h1;
            @(posedge i_clk);
            line[sel] <= 1'h0;
        end
    endtask : pulse
    // Raise two lines in the same cycle, for events that must coincide.
    task automatic pulse_pair(input int sa, input int sb);
        @(posedge i_clk);
        line <= line | (4'h1 << sa) | (4'h1 << sb);
        @(posedge i_clk);
        line <= 4'h0;
    endtask : pulse_pair
endmodule : timer0_event_model
`default_nettype wire

// ---- verification/timer0_with_fast_edge_counter_tb_top.sv ----
// Self-checking bench for timer 0 with its fast edge counter.
// Assumes the AXI4-Lite slave and the event model in timer0_event_model.
`default_nettype none
`include "timer0_params.svh"
module timer0_with_fast_edge_counter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 1'h0;
    logic i_nrst = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, port_latch = 1'h0;
    timer0_pkg::addr_t awaddr = '0, araddr = '0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid, rt, irq_h, irq_l, ext, edg, capl, caph;
    logic [1:0] bresp, rresp, rs, wresp;
    logic [31:0] rdata, r1, r2;
    logic [7:0] diff;
    // Level outputs watched by pc, picked by index: 0 realtime, 1 low irq, 2 high irq.
    logic [2:0] obs;
    assign obs = {irq_h, irq_l, rt};
    int mismatches = 0, checks_done = 0, cyc = 0, st = 0, s = 0, n = 0;
    logic [15:0] ix [8] = '{`T0_IDX_CONTROL, `T0_IDX_PRESCALE, `T0_IDX_LOW_COUNT, `T0_IDX_HIGH_COUNT,
        `T0_IDX_LOW_MATCH, `T0_IDX_HIGH_MATCH, `T0_IDX_PORT1_TEST, `T0_IDX_EDGE_CTRL};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `T0_P1_FIXED, 8'h00};
    int pl [3] = '{0, 2, 5};
    // Free-running clock and a cycle stamp for timed reads.
    always #2 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    timer0_with_fast_edge_counter dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(awvalid),
        .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0), .i_wvalid(wvalid), .o_wready(wready),
        .i_wdata(wdata), .i_wstrb(4'h1), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rvalid),
        .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_ext_count(ext), .i_edge_pulse(edg),
        .i_low_capture(capl), .i_high_capture(caph), .i_port_latch(port_latch), .o_realtime(rt),
        .o_irq_high(irq_h), .o_irq_low(irq_l));
    timer0_event_model ev (.i_clk(i_clk), .o_ext_count(ext), .o_edge_pulse(edg), .o_low_capture(capl),
        .o_high_capture(caph));
    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input logic [33:0] sn, input logic [33:0] ex);
        checks_done++;
        if (sn !== ex) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, sn, ex);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    function automatic timer0_pkg::addr_t ad(input logic [15:0] idx);
        return {idx, 2'h0};
    endfunction : ad
    // Handshakes are judged at the falling edge, where nothing is moving, and acted on at the next rise.
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        int k;
        logic a, w, b;
        @(posedge i_clk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        awaddr <= ad(idx);
        wdata <= {24'h00_0000, d};
        b = 1'h0;
        for (k = 0; k < 50 && !b; k++) begin
            @(negedge i_clk);
            a = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            wresp = bresp;
            @(posedge i_clk);
            if (a) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
            if (b) bready <= 1'h0;
        end
        if (!b) begin
            mismatches++;
            report_and_stop();
        end
    endtask : wr
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        int k;
        logic a, g;
        @(posedge i_clk);
        st = cyc;
        arvalid <= 1'h1;
        rready <= 1'h1;
        araddr <= ad(idx);
        g = 1'h0;
        for (k = 0; k < 50 && !g; k++) begin
            @(negedge i_clk);
            a = arvalid & arready;
            g = rvalid;
            d = rdata;
            r = rresp;
            @(posedge i_clk);
            if (a) arvalid <= 1'h0;
            if (g) rready <= 1'h0;
        end
        if (!g) begin
            mismatches++;
            report_and_stop();
        end
    endtask : rd
    task automatic rc(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(idx, d, r);
        chk({r, d}, {2'h0, 24'h00_0000, e});
    endtask : rc
    // The level is read at the falling edge, after the launching edge has settled.
    task automatic pc(input int sel, input logic e);
        @(negedge i_clk);
        chk(34'(obs[sel]), 34'(e));
    endtask : pc
    // Main sequence: reset, registers, both count clocks, 16-bit mode, then the edge counter.
    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'h1;
        port_latch <= 1'h1;
        pc(0, 1'h1);
        for (int i = 0; i < 8; i++) rc(ix[i], rv[i]);
        rd(16'hfe18, r1, rs);
        chk(34'(rs), 34'(`T0_RESP_SLVERR));
        wr(`T0_IDX_LOW_COUNT, 8'h55);
        chk(34'(wresp), 34'(`T0_RESP_OKAY));
        rc(`T0_IDX_LOW_COUNT, 8'h00);
        wr(`T0_IDX_LOW_MATCH, 8'h03);
        wr(`T0_IDX_CONTROL, 8'h51);
        ev.pulse(0, 3);
        rc(`T0_IDX_LOW_COUNT, 8'h03);
        wr(`T0_IDX_LOW_MATCH, 8'h01);
        rc(`T0_IDX_CONTROL, 8'h51);
        ev.pulse(0, 1);
        rc(`T0_IDX_CONTROL, 8'h53);
        pc(1, 1'h1);
        rc(`T0_IDX_LOW_COUNT, 8'h00);
        wr(`T0_IDX_CONTROL, 8'h51);
        pc(1, 1'h0);
        ev.pulse(0, 2);
        rc(`T0_IDX_LOW_COUNT, 8'h00);
        ev.pulse(0, 1);
        ev.pulse(2, 1);
        rc(`T0_IDX_LOW_CAPTURE, 8'h01);
        wr(`T0_IDX_CONTROL, 8'h00);
        rc(`T0_IDX_LOW_COUNT, 8'h00);
        // Two reads a fixed 90 cycles apart must differ by 90 over the tick period.
        wr(`T0_IDX_LOW_MATCH, 8'hff);
        wr(`T0_IDX_CONTROL, 8'h40);
        for (int i = 0; i < 3; i++) begin
            wr(`T0_IDX_PRESCALE, 8'(pl[i]));
            rd(`T0_IDX_LOW_COUNT, r1, rs);
            s = st;
            @(negedge i_clk);
            for (n = 0; n < 200 && cyc != s + 90; n++) @(negedge i_clk);
            if (cyc != s + 90) begin
                mismatches++;
                report_and_stop();
            end
            rd(`T0_IDX_LOW_COUNT, r2, rs);
            diff = r2[7:0] - r1[7:0];
            chk(34'(diff), 34'(90 / (pl[i] + 1)));
        end
        wr(`T0_IDX_CONTROL, 8'h00);
        wr(`T0_IDX_LOW_MATCH, 8'h02);
        wr(`T0_IDX_HIGH_MATCH, 8'h01);
        wr(`T0_IDX_CONTROL, 8'hf5);
        ev.pulse(0, 258);
        rc(`T0_IDX_CONTROL, 8'hf5);
        rc(`T0_IDX_HIGH_COUNT, 8'h01);
        ev.pulse(3, 1);
        rc(`T0_IDX_LOW_CAPTURE, 8'h02);
        rc(`T0_IDX_HIGH_CAPTURE, 8'h01);
        ev.pulse(0, 1);
        rc(`T0_IDX_CONTROL, 8'hff);
        pc(2, 1'h1);
        rc(`T0_IDX_HIGH_COUNT, 8'h00);
        wr(`T0_IDX_CONTROL, 8'h00);
        // Edge counter: target (1 + 1) * 8 + 3 = 19 edges.
        wr(`T0_IDX_LOW_MATCH, 8'h01);
        wr(`T0_IDX_CONTROL, 8'h50);
        wr(`T0_IDX_PORT1_TEST, 8'h04);
        rc(`T0_IDX_PORT1_TEST, 8'h24);
        wr(`T0_IDX_EDGE_CTRL, 8'hb0);
        @(posedge i_clk);
        port_latch <= 1'h0;
        ev.pulse(1, 18);
        pc(0, 1'h1);
        rc(`T0_IDX_CONTROL, 8'h50);
        ev.pulse(1, 1);
        pc(0, 1'h0);
        rc(`T0_IDX_CONTROL, 8'h52);
        rc(`T0_IDX_LOW_COUNT, 8'h02);
        wr(`T0_IDX_CONTROL, 8'h50);
        ev.pulse(1, 2048);
        rc(`T0_IDX_CONTROL, 8'h50);
        ev.pulse(2, 1);
        rc(`T0_IDX_EDGE_CTRL, 8'hb3);
        // Four more edges bring the edge count to 7; a capture on the next edge also sees its carry.
        ev.pulse(1, 4);
        ev.pulse_pair(1, 2);
        rc(`T0_IDX_EDGE_CTRL, 8'hbf);
        rd(`T0_IDX_LOW_CAPTURE, r1, rs);
        rd(`T0_IDX_EDGE_CTRL, r2, rs);
        diff = r1[7:0] + {7'h00, r2[3]};
        chk(34'(diff), 34'(8'h03));
        // Disabling the edge counter keeps the last captured carry and count readable.
        wr(`T0_IDX_EDGE_CTRL, 8'h00);
        rc(`T0_IDX_EDGE_CTRL, 8'h0f);
        report_and_stop();
    end
endmodule : timer0_with_fast_edge_counter_tb_top
`default_nettype wire
